// *** rtl/ssc_console.sv ***
// Purpose: character-driven setup console with AXI4-Lite parameter access
// Assumes: terminal on rxd/txd, AXI4-Lite master on the register port
// Notes:   menus and prompts appear as one marker character each
`timescale 1ns/10ps
`default_nettype none

module ssc_console
  import ssc_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned CLK_FREQ    = CLK_HZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ssc_state_t  state_q;
  logic [31:0] boot_cnt_q;
  logic        boot_done_q;
  logic        fast_q;
  logic [3:0]  baud_idx_q;
  logic [19:0] div_q;
  logic        send_q;
  logic [7:0]  sbyte_q;
  logic        trk_q;
  logic [3:0]  field_q;
  logic [2:0]  cnt_q;
  logic [23:0] buf_q;
  logic [7:0]  suf_q;
  logic        commit_q;
  logic [3:0]  cfield_q;
  logic        ctrk_q;
  logic        tx_busy;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        ok_char;
  logic [23:0] time_q;
  logic [23:0] date_q;
  logic [27:0] mp_q   [2];
  logic [31:0] zone_q [2];
  logic [28:0] opt_q  [2];
  logic        aw_have_q;
  logic        w_have_q;
  logic [5:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [31:0] rd_val;
  logic        rd_hit;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= CH_0 && c <= CH_9;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial link
  ssc_uart u_uart (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .div      (div_q),
    .rxd      (rxd),
    .tx_start (send_q && !tx_busy),
    .tx_data  (sbyte_q),
    .txd      (txd),
    .tx_busy  (tx_busy),
    .rx_valid (rx_valid),
    .rx_data  (rx_data)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= baud_div(BAUD_FAST_IDX, CLK_FREQ);
    else
      div_q <= baud_div(fast_q ? BAUD_FAST_IDX : baud_idx_q,
                        CLK_FREQ);
  end

  ////////////////////////////////////////////////////////////////////////////
  // character validity at the current entry position
  always_comb
  begin
    if (field_len(field_q) == 3'd1)
      ok_char = rx_data == CH_Y || rx_data == CH_N;
    else if (field_q == F_MP && cnt_q == 3'd5)
      ok_char = rx_data == CH_X || rx_data == CH_Y || rx_data == CH_Z
                || rx_data == CH_SPACE;
    else
      ok_char = is_digit(rx_data);
  end

  ////////////////////////////////////////////////////////////////////////////
  // console state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q     <= ST_BOOT;
      boot_cnt_q  <= 32'h0000_0000;
      boot_done_q <= 1'b0;
      fast_q      <= 1'b1;
      send_q      <= 1'b1;
      sbyte_q     <= PR_BOOT;
      trk_q       <= 1'b0;
      field_q     <= F_MP;
      cnt_q       <= 3'd0;
      buf_q       <= 24'h00_0000;
      suf_q       <= CH_SPACE;
      commit_q    <= 1'b0;
      cfield_q    <= F_MP;
      ctrk_q      <= 1'b0;
    end
    else
    begin
      commit_q <= 1'b0;
      if (send_q && !tx_busy)
        send_q <= 1'b0;
      unique case (state_q)
        ST_BOOT:
        begin
          boot_cnt_q <= boot_cnt_q + 32'h0000_0001;
          if (rx_valid && rx_data == CH_SPACE)
          begin
            boot_done_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
          else if (boot_cnt_q >= BOOT_CYCLES - 1)
          begin
            fast_q      <= 1'b0;
            boot_done_q <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (rx_valid && rx_data == CH_ESC)
          begin
            state_q <= ST_MAIN;
            send_q  <= 1'b1;
            sbyte_q <= PR_MAIN;
          end
        end
        ST_MAIN:
        begin
          if (rx_valid)
          begin
            if (rx_data == CH_ESC)
            begin
              send_q  <= 1'b1;
              sbyte_q <= PR_MAIN;
            end
            else if (rx_data == CH_A)
            begin
              state_q <= ST_ENTRY;
              field_q <= F_TIME;
              cnt_q   <= 3'd0;
              send_q  <= 1'b1;
              sbyte_q <= PR_TIME;
            end
            else if (rx_data == CH_B)
            begin
              state_q <= ST_TRACK;
              send_q  <= 1'b1;
              sbyte_q <= PR_TRACK;
            end
          end
        end
        ST_TRACK:
        begin
          if (rx_valid)
          begin
            if (rx_data == CH_1 || rx_data == CH_2)
            begin
              trk_q   <= rx_data == CH_2;
              state_q <= ST_SET;
              send_q  <= 1'b1;
              sbyte_q <= PR_SET;
            end
            else if (rx_data == CH_ESC)
            begin
              state_q <= ST_MAIN;
              send_q  <= 1'b1;
              sbyte_q <= PR_MAIN;
            end
          end
        end
        ST_SET:
        begin
          if (rx_valid)
          begin
            if (rx_data == CH_X || rx_data == CH_ESC)
            begin
              state_q <= ST_MAIN;
              send_q  <= 1'b1;
              sbyte_q <= PR_MAIN;
            end
            else if (rx_data == CH_N)
            begin
              commit_q <= 1'b1;
              cfield_q <= F_DEFLT;
              send_q   <= 1'b1;
              sbyte_q  <= PR_SET;
            end
            else if (rx_data >= CH_A && rx_data < CH_N)
            begin
              state_q <= ST_ENTRY;
              field_q <= 4'(rx_data - CH_A);
              cnt_q   <= 3'd0;
              send_q  <= 1'b1;
              sbyte_q <= PR_VALUE;
            end
          end
        end
        ST_ENTRY:
        begin
          if (rx_valid && (rx_data == CH_ESC || ok_char))
          begin
            if (rx_data != CH_ESC)
            begin
              buf_q <= {buf_q[19:0], rx_data[3:0]};
              suf_q <= rx_data;
              cnt_q <= cnt_q + 3'd1;
            end
            if (rx_data == CH_ESC || cnt_q == field_len(field_q) - 3'd1)
            begin
              commit_q <= rx_data != CH_ESC;
              cfield_q <= field_q;
              ctrk_q   <= trk_q;
              send_q   <= 1'b1;
              if (field_q == F_TIME)
              begin
                field_q <= F_DATE;
                cnt_q   <= 3'd0;
                sbyte_q <= PR_DATE;
              end
              else if (field_q == F_DATE)
              begin
                state_q <= ST_MAIN;
                sbyte_q <= PR_MAIN;
              end
              else
              begin
                state_q <= ST_SET;
                sbyte_q <= PR_SET;
              end
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored parameters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      time_q <= TIME_DEF;
      date_q <= DATE_DEF;
      for (int t = 0; t < 2; t++)
      begin
        mp_q[t]   <= MP_DEF;
        zone_q[t] <= ZONE_DEF;
        opt_q[t]  <= OPT_DEF;
      end
    end
    else if (commit_q)
    begin
      if (cfield_q == F_TIME)
        time_q <= buf_q;
      else if (cfield_q == F_DATE)
        date_q <= buf_q;
      else if (cfield_q == F_DEFLT)
      begin
        for (int t = 0; t < 2; t++)
        begin
          mp_q[t]   <= MP_DEF;
          zone_q[t] <= ZONE_DEF;
          opt_q[t]  <= OPT_DEF;
        end
      end
      else if (cfield_q == F_MP)
        mp_q[ctrk_q] <= {suf_q, buf_q[23:4]};
      else if (cfield_q <= F_ZONE4)
        zone_q[ctrk_q][8 * (cfield_q - 4'h1) +: 8] <= buf_q[7:0];
      else if (cfield_q <= F_FLAG4)
        opt_q[ctrk_q][OPT_FLAG_LSB + 32'(cfield_q) - 5] <= suf_q == CH_Y;
      else if (cfield_q == F_LOWBAT)
        opt_q[ctrk_q][OPT_FLAG_LSB + 4] <= suf_q == CH_Y;
      else if (cfield_q == F_DLYL)
        opt_q[ctrk_q][OPT_DLYL_LSB +: 8] <= buf_q[7:0];
      else if (cfield_q == F_DLYR)
        opt_q[ctrk_q][OPT_DLYR_LSB +: 8] <= buf_q[7:0];
      else
        opt_q[ctrk_q][OPT_RECALL_LSB +: 8] <= buf_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 6'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      baud_idx_q    <= BAUD_DEF_IDX;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_bvalid
                       && !(s_axi_awready && s_axi_awvalid);
      s_axi_wready  <= !w_have_q && !s_axi_bvalid
                       && !(s_axi_wready && s_axi_wvalid);
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= {awaddr_q[5:2], 2'b00} > REG_OPT1 ? RESP_SLVERR
                                                           : RESP_OKAY;
        if ({awaddr_q[5:2], 2'b00} == REG_CFG && wstrb_q[0]
            && wdata_q[3:0] <= BAUD_MAX_IDX)
          baud_idx_q <= wdata_q[3:0];
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb
  begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      REG_CFG:   rd_val = {28'h000_0000, baud_idx_q};
      REG_STAT:  rd_val = {26'h000_0000, trk_q, fast_q, boot_done_q,
                           state_q};
      REG_TIME:  rd_val = {8'h00, time_q};
      REG_DATE:  rd_val = {8'h00, date_q};
      REG_MP0:   rd_val = {4'h0, mp_q[0]};
      REG_MP1:   rd_val = {4'h0, mp_q[1]};
      REG_ZONE0: rd_val = zone_q[0];
      REG_ZONE1: rd_val = zone_q[1];
      REG_OPT0:  rd_val = {3'h0, opt_q[0]};
      REG_OPT1:  rd_val = {3'h0, opt_q[1]};
      default:
      begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arready && s_axi_arvalid);
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ssc_console

`default_nettype wire

// *** rtl/ssc_pkg.sv ***
// Purpose: constants and types for the serial setup console
// Assumes: 200 MHz aclk, 8N1 console characters
// Notes:   prompts are single marker characters, values are read over the bus
//
// How it works
// - console characters are 8 data bits, no parity, one stop, full duplex
// - stored console rate selectable from 300 up to 115200 baud
// - after reset run at 115200, announce, switch to stored rate after 5 s
// - a space inside the 5 s window cancels the switch and keeps 115200
// - after boot an escape sends the main menu; one letter picks a function
// - letter A at main menu starts time and date setting with time prompt
// - time is six digits hhmmss; sixth digit or escape leads to date prompt
// - date is six digits mmddyy; sixth digit or escape returns to main menu
// - escape during entry abandons it and leaves the stored value alone
// - parameter setting asks for track 1 or 2; each track stores its own
// - settings letters A to N pick items in order, X leaves the menu
// - milepost is five digits and a suffix X, Y, Z or space
// - each zone number is two digits 00 to 99; 00 disables that input
// - four alarm inputs hold fixed roles, each with its own zone number
// - load defaults restores milepost, zone and option words of both tracks; time and date are kept
`default_nettype none

package ssc_pkg;

  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned BOOT_TIME_S = 5;
  localparam int unsigned BOOT_CYC    = BOOT_TIME_S * CLK_HZ;

  localparam logic [3:0] BAUD_FAST_IDX = 4'h8;
  localparam logic [3:0] BAUD_DEF_IDX  = 4'h4;
  localparam logic [3:0] BAUD_MAX_IDX  = 4'h8;

  // console rates by index
  function automatic int unsigned baud_rate(input logic [3:0] idx);
    case (idx)
      4'h0:    return 300;
      4'h1:    return 1200;
      4'h2:    return 2400;
      4'h3:    return 4800;
      4'h4:    return 9600;
      4'h5:    return 19200;
      4'h6:    return 38400;
      4'h7:    return 57600;
      default: return 115200;
    endcase
  endfunction

  // bit time in clock cycles for a given clock rate
  function automatic logic [19:0] baud_div(input logic [3:0]  idx,
                                           input int unsigned clk_hz);
    return 20'(clk_hz / baud_rate(idx));
  endfunction

  localparam logic [7:0] CH_ESC   = 8'h1B;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_1     = 8'h31;
  localparam logic [7:0] CH_2     = 8'h32;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_B     = 8'h42;
  localparam logic [7:0] CH_N     = 8'h4E;
  localparam logic [7:0] CH_X     = 8'h58;
  localparam logic [7:0] CH_Y     = 8'h59;
  localparam logic [7:0] CH_Z     = 8'h5A;

  // prompt markers sent to the terminal
  localparam logic [7:0] PR_BOOT  = 8'h42;
  localparam logic [7:0] PR_MAIN  = 8'h4D;
  localparam logic [7:0] PR_TRACK = 8'h4B;
  localparam logic [7:0] PR_SET   = 8'h53;
  localparam logic [7:0] PR_TIME  = 8'h54;
  localparam logic [7:0] PR_DATE  = 8'h44;
  localparam logic [7:0] PR_VALUE = 8'h56;

  localparam logic [5:0] REG_CFG   = 6'h00;
  localparam logic [5:0] REG_STAT  = 6'h04;
  localparam logic [5:0] REG_TIME  = 6'h08;
  localparam logic [5:0] REG_DATE  = 6'h0C;
  localparam logic [5:0] REG_MP0   = 6'h10;
  localparam logic [5:0] REG_MP1   = 6'h14;
  localparam logic [5:0] REG_ZONE0 = 6'h18;
  localparam logic [5:0] REG_ZONE1 = 6'h1C;
  localparam logic [5:0] REG_OPT0  = 6'h20;
  localparam logic [5:0] REG_OPT1  = 6'h24;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [23:0] TIME_DEF = 24'h00_0000;
  localparam logic [23:0] DATE_DEF = 24'h01_0100;
  localparam logic [27:0] MP_DEF   = 28'h200_0000;
  localparam logic [31:0] ZONE_DEF = 32'h0000_0000;
  localparam logic [28:0] OPT_DEF  = 29'h0015_0000;

  // option word fields
  localparam int unsigned OPT_DLYL_LSB   = 0;
  localparam int unsigned OPT_DLYR_LSB   = 8;
  localparam int unsigned OPT_RECALL_LSB = 16;
  localparam int unsigned OPT_FLAG_LSB   = 24;

  // entry fields: settings letter offset, then time and date
  localparam logic [3:0] F_MP     = 4'h0;
  localparam logic [3:0] F_ZONE4  = 4'h4;
  localparam logic [3:0] F_FLAG4  = 4'h8;
  localparam logic [3:0] F_DLYL   = 4'h9;
  localparam logic [3:0] F_DLYR   = 4'hA;
  localparam logic [3:0] F_RECALL = 4'hB;
  localparam logic [3:0] F_LOWBAT = 4'hC;
  localparam logic [3:0] F_DEFLT  = 4'hD;
  localparam logic [3:0] F_TIME   = 4'hE;
  localparam logic [3:0] F_DATE   = 4'hF;

  // characters needed by each field
  function automatic logic [2:0] field_len(input logic [3:0] f);
    if (f == F_MP || f == F_TIME || f == F_DATE)
      return 3'd6;
    else if (f <= F_ZONE4 || (f >= F_DLYL && f <= F_RECALL))
      return 3'd2;
    else
      return 3'd1;
  endfunction

  typedef enum logic [2:0] {
    ST_BOOT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_MAIN  = 3'b010,
    ST_TRACK = 3'b011,
    ST_SET   = 3'b100,
    ST_ENTRY = 3'b101
  } ssc_state_t;

endpackage

`default_nettype wire

// *** rtl/ssc_uart.sv ***
// Purpose: 8N1 serial transmitter and receiver with run-time divisor
// Assumes: rxd synchronous to aclk
// Notes:   a start bit that is gone at mid-bit is dropped as a glitch
`timescale 1ns/10ps
`default_nettype none

module ssc_uart (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [19:0] div,
  input  wire logic        rxd,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_data,
  output logic             txd,
  output logic             tx_busy,
  output logic             rx_valid,
  output logic [7:0]       rx_data
);

  logic [19:0] tcnt_q;
  logic [19:0] rcnt_q;
  logic [3:0]  tbit_q;
  logic [3:0]  rbit_q;
  logic [8:0]  tsh_q;
  logic        rbusy_q;

  ////////////////////////////////////////////////////////////////////////////
  // transmit: start, eight data bits lsb first, stop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd     <= 1'b1;
      tx_busy <= 1'b0;
      tcnt_q  <= 20'h0_0000;
      tbit_q  <= 4'h0;
      tsh_q   <= 9'h1FF;
    end
    else if (!tx_busy)
    begin
      if (tx_start)
      begin
        tx_busy <= 1'b1;
        txd     <= 1'b0;
        tsh_q   <= {1'b1, tx_data};
        tcnt_q  <= div - 20'h0_0001;
        tbit_q  <= 4'h0;
      end
    end
    else if (tcnt_q != 20'h0_0000)
      tcnt_q <= tcnt_q - 20'h0_0001;
    else if (tbit_q == 4'h9)
      tx_busy <= 1'b0;
    else
    begin
      txd    <= tsh_q[0];
      tsh_q  <= {1'b1, tsh_q[8:1]};
      tbit_q <= tbit_q + 4'h1;
      tcnt_q <= div - 20'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive: sample mid-bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rbusy_q  <= 1'b0;
      rcnt_q   <= 20'h0_0000;
      rbit_q   <= 4'h0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!rbusy_q)
      begin
        if (!rxd)
        begin
          rbusy_q <= 1'b1;
          rcnt_q  <= {1'b0, div[19:1]};
          rbit_q  <= 4'h0;
        end
      end
      else if (rcnt_q != 20'h0_0000)
        rcnt_q <= rcnt_q - 20'h0_0001;
      else if (rbit_q == 4'h0 && rxd)
        rbusy_q <= 1'b0;
      else if (rbit_q == 4'h9)
      begin
        rbusy_q  <= 1'b0;
        rx_valid <= rxd;
      end
      else
      begin
        if (rbit_q != 4'h0)
          rx_data <= {rxd, rx_data[7:1]};
        rbit_q <= rbit_q + 4'h1;
        rcnt_q <= div - 20'h0_0001;
      end
    end
  end

endmodule // ssc_uart

`default_nettype wire

// *** tb/ssc_console_monitor.sv ***
// Purpose: port checker for the setup console
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every console instance
`timescale 1ns/10ps
`default_nettype none

module ssc_console_monitor
  import ssc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        txd,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  rd_answer_a: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_release_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  wr_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  wr_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  bad_read_a: assert property (
    s_rd_take ##0 (s_axi_araddr[5:2] > REG_OPT1[5:2]) |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  bad_write_a: assert property (
    s_wr_both ##0 (s_axi_awaddr[5:2] > REG_OPT1[5:2]) |->
    ##[1:3] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");
  start_bit_a: assert property ($fell(txd) |=> !txd [*8])
    else $error("start bit too short");
  boot_mark_a: assert property ($rose(aresetn) |-> ##[1:4] !txd)
    else $error("no start-up marker");

endmodule // ssc_console_monitor

bind ssc_console ssc_console_monitor u_mon (
  .aclk, .aresetn, .txd, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

// *** tb/ssc_console_tb.sv ***
// Purpose: self-checking bench for the setup console
// Assumes: start-up window and bit time cut to keep the run short
// Notes:   each marker is checked after the next key is sent
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("MISMATCH %0t got %h exp %h", $time, a, e); \
    end \
  end

module ssc_console_tb
  import ssc_pkg::*;
;
  localparam int BOOT = 4000;
  localparam int CLKF = 1_843_200;
  logic        aclk, aresetn, rxd, txd;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  want = 8'h00;
  int          miscompares = 0, cmp_count = 0;

  ssc_console #(.BOOT_CYCLES(BOOT), .CLK_FREQ(CLKF)) u_dut (
    .aclk, .aresetn, .rxd, .txd, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ssc_terminal #(.BIT(16)) u_term (.aclk(aclk), .txd(txd), .rxd(rxd));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [5:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
  endtask

  // sends a key, then checks the marker of the key before
  task automatic key(input logic [7:0] c, input logic [7:0] m);
    logic [7:0] g;
    u_term.send(c);
    g = (u_term.got.size() > 0) ? u_term.got.pop_front() : 8'hxx;
    if (want !== 8'h00)
      `CHK(g, want)
    want = m;
  endtask

  // sends the n low BCD digits of v, most significant first
  task automatic digits(input logic [23:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      u_term.send({4'h3, v[4*i +: 4]});
  endtask

  task automatic boot_wait();
    int n = 0;
    do
    begin
      axr(REG_STAT);
      n++;
    end while (rdat[3] !== 1'b1 && n < 2000);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end

  ////////////////////////////////////////
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    u_term.send(CH_SPACE);
    boot_wait();
    `CHK(rdat[4:3], 2'b11)
    `CHK(u_term.got[0], PR_BOOT)
    u_term.got.delete();
    axr(REG_CFG);
    `CHK(rdat, 32'h0000_0004)
    axw(REG_CFG, 32'h0000_0000);
    axw(REG_CFG, 32'h0000_0009);
    axr(REG_CFG);
    `CHK(rdat, 32'h0000_0000)
    axw(6'h28, 32'h0000_0001);
    `CHK(rsp, RESP_SLVERR)
    axr(6'h28);
    `CHK(rsp, RESP_SLVERR)
    key(CH_ESC, PR_MAIN);
    key(CH_A, PR_TIME);
    key(CH_ESC, PR_DATE);
    key(CH_ESC, PR_MAIN);
    axr(REG_TIME);
    `CHK(rdat[23:0], TIME_DEF)
    key(CH_A, PR_TIME);
    digits(24'h01_5492, 5);
    key(8'h36, PR_DATE);
    digits(24'h00_0004, 2);
    key(CH_ESC, PR_MAIN);
    axr(REG_TIME);
    `CHK(rdat[23:0], 24'h15_4926)
    axr(REG_DATE);
    `CHK(rdat[23:0], DATE_DEF)
    key(CH_B, PR_TRACK);
    key(CH_2, PR_SET);
    axr(REG_STAT);
    `CHK(rdat[5], 1'b1)
    key(8'h43, PR_VALUE);
    u_term.send(8'h34);
    u_term.send(CH_Z);
    key(8'h37, PR_SET);
    axr(REG_ZONE1);
    `CHK(rdat, 32'h0000_4700)
    key(CH_A, PR_VALUE);
    digits(24'h00_0870, 5);
    key(CH_X, PR_SET);
    axr(REG_MP1);
    `CHK(rdat, 32'h0580_0870)
    key(CH_N, PR_SET);
    axr(REG_ZONE1);
    `CHK(rdat, ZONE_DEF)
    key(CH_X, PR_MAIN);
    key(8'hff, 8'h00);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    boot_wait();
    `CHK(rdat[4:3], 2'b01)
    complete_run();
  end

endmodule // ssc_console_tb

`default_nettype wire

// *** tb/ssc_terminal.sv ***
// Purpose: terminal model on the console serial link
// Assumes: 8N1, BIT aclk cycles per bit
// Notes:   each sent character is followed by two idle bits
`timescale 1ns/10ps
`default_nettype none

module ssc_terminal #(
  parameter int BIT = 1736
) (
  input  wire logic aclk,
  input  wire logic txd,
  output var logic  rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rxd = 1'b1;

  // start, eight data bits lsb first, stop, two idle bits
  task automatic send(input logic [7:0] c);
    for (int i = 0; i < 12; i++)
    begin
      rxd <= (i == 0) ? 1'b0 : (i < 9) ? c[i-1] : 1'b1;
      repeat (BIT) @(posedge aclk);
    end
  endtask

  // receiver runs alongside the sender
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge aclk);
      sh = {txd, sh[7:1]};
    end
    repeat (BIT) @(posedge aclk);
    if (txd)
      got.push_back(sh);
  end

endmodule // ssc_terminal

`default_nettype wire
